// ### hw/agc_stage.sv
// angle post-processing: zero-reference shift, gain, inversion, clamp, temperature capture
// assumes the angle input is already rotated and synchronous to sys_clk_i; nvm load pulse is synchronous
`timescale 1ns/1ps
`include "agc_defs.svh"

module agc_stage #(
  parameter int ANGLE_W = 16
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // nonvolatile image load
  input  wire logic                  nvm_load_i,
  input  wire agc_pkg::agc_nvm_s     nvm_image_i,
  // angle path
  input  wire logic                  angle_valid_i,
  input  wire logic [15:0]           angle_i,
  output      agc_pkg::agc_angle_s   angle_o,
  // temperature monitor
  input  wire logic                  temp_valid_i,
  input  wire logic                  temp_out_of_range_i,
  input  wire logic [15:0]           temp_value_i,
  output      logic                  temperature_fault_flag_o,
  // axi4-lite slave
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import agc_pkg::*;

  // elaboration check: the datapath and the register fields are built for a 16-bit angle only
  if (ANGLE_W != 16)
  begin : g_width_check
    $error("agc_stage serves only a 16-bit angle");
  end

  // configuration and capture registers
  logic [15:0] high_output_limit_q;
  logic [15:0] low_output_limit_q;
  logic [15:0] zero_reference_shift_q;
  logic [15:0] gain_q;
  logic [15:0] captured_overtemp_value_q;
  logic [15:0] captured_overrange_angle_q;
  logic        short_stroke_q;
  logic        angle_inversion_select_q;
  logic        temp_fault_q;

  // axi write side
  logic        aw_held_q;
  logic        w_held_q;
  logic [3:0]  aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] wr_mask;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // byte enables expanded into a bit mask
  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_mask
      assign wr_mask[b*8 +: 8] = {8{wstrb_q[b]}};
    end
  endgenerate

  // address and data taken in either order, held until the write commits
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_idx_q      <= 4'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[5:2];
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_idx_q inside {`AGC_IDX_LIMIT, `AGC_IDX_GAIN, `AGC_IDX_CAPTURE,
                                        `AGC_IDX_CTRL, `AGC_IDX_STATUS}) ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // merge helper for byte-lane writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  logic [31:0] lim_w;
  logic [31:0] gain_w;
  logic [31:0] cap_w;
  logic [31:0] ctrl_w;
  assign lim_w  = merge({high_output_limit_q, low_output_limit_q}, wdata_q, wr_mask);
  assign gain_w = merge({zero_reference_shift_q, gain_q}, wdata_q, wr_mask);
  assign cap_w  = merge({captured_overtemp_value_q, captured_overrange_angle_q}, wdata_q, wr_mask);
  assign ctrl_w = merge({7'h0, short_stroke_q, 1'b0, angle_inversion_select_q, 22'h0}, wdata_q, wr_mask);

  // limit, offset and gain fields: nvm load with padding, else full 16-bit software writes
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      high_output_limit_q      <= 16'hffff;
      low_output_limit_q       <= 16'h0000;
      zero_reference_shift_q   <= 16'h0000;
      gain_q                   <= 16'h0000;
      short_stroke_q           <= 1'b0;
      angle_inversion_select_q <= 1'b0;
    end
    else if (nvm_load_i)
    begin
      // [R11] [R15]
      high_output_limit_q <= (nvm_image_i.harmonic_limit_setting > `AGC_HAR_LIMIT_HI) ? `AGC_HI_FORCED
                             : {nvm_image_i.high_limit, 4'h0};
      // [R12] [R16]
      low_output_limit_q  <= (nvm_image_i.harmonic_limit_setting > `AGC_HAR_LIMIT_HI) ? 16'h0000
                             : {nvm_image_i.low_limit, 4'h0};
      // [R11] [R16]
      zero_reference_shift_q <= (nvm_image_i.harmonic_limit_setting > `AGC_HAR_OFFSET) ? 16'h0000
                                : {nvm_image_i.zero_ref, 4'h0};
      // [R13] [R16]
      gain_q <= (nvm_image_i.harmonic_limit_setting > `AGC_HAR_OFFSET) ? 16'h0000
                : {4'h0, nvm_image_i.gain};
      short_stroke_q           <= nvm_image_i.short_stroke;
      angle_inversion_select_q <= nvm_image_i.angle_inversion_select;
    end
    else if (wr_fire)
    begin
      unique case (aw_idx_q)
        `AGC_IDX_LIMIT:
        begin
          high_output_limit_q <= lim_w[31:16]; // [R14]
          low_output_limit_q  <= lim_w[15:0];
        end
        `AGC_IDX_GAIN:
        begin
          zero_reference_shift_q <= gain_w[31:16]; // [R14]
          gain_q                 <= gain_w[15:0];
        end
        `AGC_IDX_CTRL:
        begin
          short_stroke_q           <= ctrl_w[`AGC_CTRL_SS_BIT];
          angle_inversion_select_q <= ctrl_w[`AGC_CTRL_IV_BIT];
        end
        default:
        begin
        end
      endcase
    end
  end

  // processing, stage 1: offset shift (always), then gain in 8.8 fixed point
  logic [15:0] shifted;
  logic [16:0] gain_eff;
  logic [32:0] product;
  logic [15:0] scaled;
  assign shifted  = angle_i - zero_reference_shift_q; // [R06] [R07] [R21]
  assign gain_eff = {1'b0, gain_q} + 17'h00100;        // [R08] [R09]
  assign product  = {1'b0, shifted} * {16'h0, gain_eff};
  // truncation keeps the low 16 integer bits, so products of one turn or more wrap the turn
  assign scaled   = short_stroke_q ? product[`AGC_GAIN_FRAC +: 16] : shifted; // [R19] [R21]

  // stage 2: inversion, then clamp as the very last step
  logic [15:0] inverted;
  logic [15:0] clamped;
  assign inverted = angle_inversion_select_q ? (high_output_limit_q - scaled) : scaled; // [R20]
  always_comb
  begin
    clamped = inverted;
    if (short_stroke_q) // [R19] [R03]
    begin
      if (inverted > high_output_limit_q)
        clamped = high_output_limit_q; // [R01] [R05]
      else if (inverted < low_output_limit_q)
        clamped = low_output_limit_q;  // [R02] [R05]
    end
  end

  // registered output, one cycle after the input sample
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      angle_o <= '0;
    else
    begin
      angle_o.valid <= angle_valid_i;
      if (angle_valid_i)
        angle_o.angle <= clamped;
    end
  end

  // temperature capture, raw count in eighths of a kelvin; event wins over a clear
  logic temp_event;
  assign temp_event = temp_valid_i && temp_out_of_range_i;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      captured_overtemp_value_q  <= 16'h0000;
      captured_overrange_angle_q <= 16'h0000;
      temp_fault_q               <= 1'b0;
    end
    else
    begin
      if (wr_fire && aw_idx_q == `AGC_IDX_CAPTURE)
      begin
        captured_overtemp_value_q  <= cap_w[31:16];
        captured_overrange_angle_q <= cap_w[15:0];
      end
      if (temp_event)
        captured_overtemp_value_q <= temp_value_i; // [R17] [R18]
      if (temp_event)
        temp_fault_q <= 1'b1; // [R17]
      else if (wr_fire && aw_idx_q == `AGC_IDX_STATUS && wstrb_q[0] && wdata_q[`AGC_STAT_TF_BIT])
        temp_fault_q <= 1'b0;
    end
  end
  assign temperature_fault_flag_o = temp_fault_q;

  // read channel; unmapped addresses answer slverr with zero data
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        unique case (s_axi_araddr[5:2])
          `AGC_IDX_LIMIT:   s_axi_rdata <= {high_output_limit_q, low_output_limit_q};
          `AGC_IDX_GAIN:    s_axi_rdata <= {zero_reference_shift_q, gain_q};
          `AGC_IDX_CAPTURE: s_axi_rdata <= {captured_overtemp_value_q, captured_overrange_angle_q};
          `AGC_IDX_CTRL:    s_axi_rdata <= {7'h0, short_stroke_q, 1'b0, angle_inversion_select_q, 22'h0};
          `AGC_IDX_STATUS:  s_axi_rdata <= {31'h0, temp_fault_q};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  a_clamp_high_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R01]
    angle_valid_i && short_stroke_q && inverted > high_output_limit_q |=> angle_o.angle == $past(high_output_limit_q))
    else $error("high limit not applied");
  a_clamp_low_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R02]
    angle_valid_i && short_stroke_q && inverted < low_output_limit_q && inverted <= high_output_limit_q
    |=> angle_o.angle == $past(low_output_limit_q))
    else $error("low limit not applied");
  a_bypass_no_gain: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R19]
    angle_valid_i && !short_stroke_q && !angle_inversion_select_q
    |=> angle_o.angle == $past(angle_i) - $past(zero_reference_shift_q))
    else $error("bypass path altered angle");
  a_unity_gain: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R08]
    short_stroke_q && gain_q == 16'h0 |-> scaled == shifted)
    else $error("zero gain field is not unity");
  a_load_high_forced: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R15]
    nvm_load_i && nvm_image_i.harmonic_limit_setting > 4'ha |=> high_output_limit_q == 16'hfff0)
    else $error("high limit not forced");
  a_load_pad_low: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R12]
    nvm_load_i |=> low_output_limit_q[3:0] == 4'h0)
    else $error("low limit padding wrong");
  a_load_gain_top: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R13]
    nvm_load_i
    |=> gain_q == (($past(nvm_image_i.harmonic_limit_setting) > 4'hb) ? 16'h0000 : {4'h0, $past(nvm_image_i.gain)}))
    else $error("gain load wrong");
  a_load_offset_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R16]
    nvm_load_i && nvm_image_i.harmonic_limit_setting > 4'hb |=> zero_reference_shift_q == 16'h0 && gain_q == 16'h0)
    else $error("offset or gain not cleared");
  a_temp_capture: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R17]
    temp_event |=> temperature_fault_flag_o && captured_overtemp_value_q == $past(temp_value_i))
    else $error("temperature not captured");
  a_invert_path: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R20]
    angle_valid_i && angle_inversion_select_q && !short_stroke_q
    |=> angle_o.angle == $past(high_output_limit_q) - $past(shifted))
    else $error("inversion wrong");

endmodule

// ### hw/agc_defs.svh
// register offsets, field positions, load values and the gain fraction for the angle gain clamp stage
// assumes an axi4-lite slave with 32-bit data; offsets are word indices, byte address is four times
//
// Overview of operation
// [R01] short-stroke on: above high limit outputs high
// [R02] short-stroke on: below low limit outputs low
// [R03] limit clamp is the last step
// [R04] software disables clamp with 65535 and 0
// [R05] limits in 65536 counts per turn
// [R06] subtract zero reference before gain
// [R07] zero reference subtraction ignores short-stroke bit
// [R08] gain multiplies by one plus field
// [R09] gain field is 8.8 unsigned fixed point
// [R10] software keeps gain at most sixteen
// [R11] high limit, zero reference: low nibble zero-filled
// [R12] low limit loads 15:4, clears 3:0
// [R13] gain loads 11:0, clears 15:12
// [R14] all sixteen bits writable after load
// [R15] harmonic setting above 10 loads high 0xfff0
// [R16] clear low above 10, offset/gain above 11
// [R17] out-of-range temperature captured and flagged
// [R18] temperature count is eighths of a kelvin
// [R19] short-stroke bit gates limits and gain
// [R20] inversion outputs high limit minus angle
// [R21] wrap offset, truncate gain product to 16
`ifndef AGC_DEFS_SVH
`define AGC_DEFS_SVH

`define AGC_IDX_LIMIT    4'h2
`define AGC_IDX_GAIN     4'h3
`define AGC_IDX_CAPTURE  4'h4
`define AGC_IDX_CTRL     4'h6
`define AGC_IDX_STATUS   4'h7

`define AGC_CTRL_SS_BIT  24
`define AGC_CTRL_IV_BIT  22
`define AGC_STAT_TF_BIT  0

`define AGC_HAR_LIMIT_HI 4'ha
`define AGC_HAR_OFFSET   4'hb
`define AGC_HI_FORCED    16'hfff0
`define AGC_GAIN_FRAC    8

`endif

// ### hw/agc_pkg.sv
// types shared by the angle gain clamp stage
// assumes agc_defs.svh is available on the include path
package agc_pkg;

  // nonvolatile image delivered at initialisation
  typedef struct packed {
    logic [11:0] high_limit;
    logic [11:0] low_limit;
    logic [11:0] zero_ref;
    logic [11:0] gain;
    logic [3:0]  harmonic_limit_setting;
    logic        short_stroke;
    logic        angle_inversion_select;
  } agc_nvm_s;

  // processed angle result
  typedef struct packed {
    logic [15:0] angle;
    logic        valid;
  } agc_angle_s;

endpackage

// ### bench/tb_agc_stage.sv
// self-checking bench for the angle gain clamp stage: axi4-lite register access, nvm load, angle path, temperature
// assumes agc_pkg is compiled first and agc_defs.svh is on the include path
`timescale 1ns/1ps
`include "agc_defs.svh"

module tb_agc_stage;
  import agc_pkg::*;

  // register byte addresses, four times the word index
  localparam logic [31:0] A_LIM = {26'h0, `AGC_IDX_LIMIT, 2'b00};
  localparam logic [31:0] A_GN  = {26'h0, `AGC_IDX_GAIN, 2'b00};
  localparam logic [31:0] A_CAP = {26'h0, `AGC_IDX_CAPTURE, 2'b00};
  localparam logic [31:0] A_CTL = {26'h0, `AGC_IDX_CTRL, 2'b00};
  localparam logic [31:0] A_ST  = {26'h0, `AGC_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_BAD = 32'h0000_0014;
  localparam logic [31:0] SS    = 32'h1 << `AGC_CTRL_SS_BIT;
  localparam logic [31:0] IV    = 32'h1 << `AGC_CTRL_IV_BIT;

  // design inputs, all driven from time zero
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        nvm_load = 1'b0;
  agc_nvm_s    nvm_image = '0;
  logic        angle_valid = 1'b0;
  logic [15:0] angle = 16'h0;
  logic        temp_valid = 1'b0;
  logic        temp_oor = 1'b0;
  logic [15:0] temp_value = 16'h0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  // design outputs
  agc_angle_s  angle_o;
  logic        flag;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          n_errors = 0;
  int          n_checks = 0;

  agc_stage uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .nvm_load_i(nvm_load), .nvm_image_i(nvm_image),
    .angle_valid_i(angle_valid), .angle_i(angle), .angle_o(angle_o),
    .temp_valid_i(temp_valid), .temp_out_of_range_i(temp_oor), .temp_value_i(temp_value),
    .temperature_fault_flag_o(flag),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // 200 mhz clock
  initial
  begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one write; ready and response are sampled at the negedge, which equals their value at the next rising edge
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w, b, done;
    logic [1:0] r;
    int n;
    done = 0;
    n = 0;
    @(posedge sys_clk_i);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!done && n < 200)
    begin
      @(negedge sys_clk_i);
      aw = awready; w = wready; b = bvalid; r = bresp;
      @(posedge sys_clk_i);
      if (aw) awvalid <= 0;
      if (w) wvalid <= 0;
      if (b)
      begin
        bready <= 0;
        done = 1;
      end
      n++;
    end
    chk("bresp", {30'h0, er}, done ? {30'h0, r} : 32'hdead_dead);
  endtask

  // one read, compared against the expected word and response
  task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rv, done;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    done = 0;
    n = 0;
    @(posedge sys_clk_i);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!done && n < 200)
    begin
      @(negedge sys_clk_i);
      ar = arready; rv = rvalid; d = rdata; r = rresp;
      @(posedge sys_clk_i);
      if (ar) arvalid <= 0;
      if (rv)
      begin
        rready <= 0;
        done = 1;
      end
      n++;
    end
    chk("rresp", {30'h0, er}, done ? {30'h0, r} : 32'hdead_dead);
    chk("rdata", ed, d);
  endtask

  task automatic load(input logic [11:0] hi, lo, zr, gn, input logic [3:0] har);
    @(posedge sys_clk_i);
    nvm_image <= '{hi, lo, zr, gn, har, 1'b0, 1'b0};
    nvm_load <= 1;
    @(posedge sys_clk_i);
    nvm_load <= 0;
  endtask

  // one angle sample; the result is valid one edge later
  task automatic ang(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    angle <= a;
    angle_valid <= 1;
    @(posedge sys_clk_i);
    angle_valid <= 0;
    @(negedge sys_clk_i);
    chk("angle_valid", 32'h1, {31'h0, angle_o.valid});
    chk("angle", {16'h0, exp}, {16'h0, angle_o.angle});
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    results();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 0;
    axr(A_LIM, 32'hffff_0000, 2'b00);
    axr(A_GN, 32'h0, 2'b00);
    axr(A_BAD, 32'h0, 2'b10);
    axw(A_BAD, 32'h1234_5678, 4'hf, 2'b10);
    // nvm load pads, then the harmonic setting thresholds
    load(12'habc, 12'h123, 12'h456, 12'hfff, 4'h0);
    axr(A_LIM, 32'habc0_1230, 2'b00);
    axr(A_GN, 32'h4560_0fff, 2'b00);
    load(12'habc, 12'h123, 12'h456, 12'h58c, 4'ha);
    axr(A_LIM, 32'habc0_1230, 2'b00);
    load(12'habc, 12'h123, 12'h456, 12'h58c, 4'hb);
    axr(A_LIM, 32'hfff0_0000, 2'b00);
    axr(A_GN, 32'h4560_058c, 2'b00);
    load(12'habc, 12'h123, 12'h456, 12'h58c, 4'hc);
    axr(A_GN, 32'h0, 2'b00);
    // full width write, then a single byte lane
    axw(A_GN, 32'hffff_ffff, 4'hf, 2'b00);
    axr(A_GN, 32'hffff_ffff, 2'b00);
    axw(A_GN, 32'h0000_0000, 4'h1, 2'b00);
    axr(A_GN, 32'hffff_ff00, 2'b00);
    // short stroke off: offset wraps, no gain, no clamp
    axw(A_LIM, 32'h8000_1000, 4'hf, 2'b00);
    axw(A_GN, 32'h0020_0100, 4'hf, 2'b00);
    axw(A_CTL, 32'h0, 4'hf, 2'b00);
    ang(16'h0010, 16'hfff0);
    ang(16'h9020, 16'h9000);
    // short stroke on: gains of two, one and a half and one, clamp both sides
    axw(A_GN, 32'h1000_0100, 4'hf, 2'b00);
    axw(A_CTL, SS, 4'hf, 2'b00);
    ang(16'h3000, 16'h4000);
    ang(16'h6000, 16'h8000);
    ang(16'h1400, 16'h1000);
    ang(16'h0800, 16'h8000);
    axw(A_GN, 32'h0000_0080, 4'hf, 2'b00);
    ang(16'h2000, 16'h3000);
    axw(A_GN, 32'h0000_0000, 4'hf, 2'b00);
    ang(16'h2000, 16'h2000);
    axw(A_LIM, 32'hffff_0000, 4'hf, 2'b00);
    axw(A_GN, 32'h0000_0100, 4'hf, 2'b00);
    ang(16'hc000, 16'h8000);
    // inversion against the high limit, clamp still last
    axw(A_LIM, 32'h8000_1000, 4'hf, 2'b00);
    axw(A_GN, 32'h0, 4'hf, 2'b00);
    axw(A_CTL, SS | IV, 4'hf, 2'b00);
    ang(16'h3000, 16'h5000);
    ang(16'h7800, 16'h1000);
    // inversion alone: no gain and no clamp, so the result wraps below zero
    axw(A_CTL, IV, 4'hf, 2'b00);
    ang(16'h9000, 16'hf000);
    // temperature: a reading in range is ignored, out of range is captured
    axw(A_CAP, 32'h0, 4'hf, 2'b00);
    @(posedge sys_clk_i);
    temp_valid <= 1; temp_value <= 16'h0555;
    @(posedge sys_clk_i);
    temp_valid <= 0;
    @(negedge sys_clk_i);
    chk("fault_flag", 32'h0, {31'h0, flag});
    @(posedge sys_clk_i);
    temp_valid <= 1; temp_oor <= 1; temp_value <= 16'h0aab;
    @(posedge sys_clk_i);
    temp_valid <= 0; temp_oor <= 0;
    @(negedge sys_clk_i);
    chk("fault_flag", 32'h1, {31'h0, flag});
    axr(A_CAP, 32'h0aab_0000, 2'b00);
    axw(A_ST, 32'h1 << `AGC_STAT_TF_BIT, 4'hf, 2'b00);
    @(negedge sys_clk_i);
    chk("fault_flag", 32'h0, {31'h0, flag});
    // reset in mid-run brings back the open limits and a cleared control word
    @(posedge sys_clk_i);
    rst_i <= 1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 0;
    axr(A_LIM, 32'hffff_0000, 2'b00);
    axr(A_CTL, 32'h0, 2'b00);
    results();
  end

endmodule
